// [hdl/smc_sleep_ctrl.v]
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "smc_regs.vh"

module smc_sleep_ctrl #(
    parameter integer TICK_CYCLES = `SMC_TICK_US * `SMC_CLK_MHZ,
    parameter integer HIB_WAKE_CYCLES = `SMC_HIB_WAKE_US * `SMC_CLK_MHZ,
    parameter integer DOZE_WAKE_CYCLES = `SMC_DOZE_WAKE_US * `SMC_CLK_MHZ,
    parameter integer CYC_WAKE_CYCLES = `SMC_CYC_WAKE_US * `SMC_CLK_MHZ
) (
    input wire aclk, // system clock
    input wire aresetn, // synchronous reset, active low
    input wire [3:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output reg s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output reg s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [3:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output reg s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire sleep_request_pin, // host sleep request, high asks for sleep
    input wire link_busy, // transmit, receive or association under way
    input wire serial_activity, // serial byte seen this cycle
    input wire radio_activity, // radio frame seen this cycle
    input wire poll_no_data, // coordinator answered poll with nothing queued
    output reg cts_n, // clear-to-send, low when ready
    output reg asleep, // low-power state
    output reg input_enable, // serial and radio inputs accepted
    output reg poll_req // one-cycle poll request to coordinator
);

////////////////////////////////////////////////////////////////////////////////
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_DRAIN = 3'h1;
localparam [2:0] ST_SLEEP = 3'h2;
localparam [2:0] ST_WAKE = 3'h3;
localparam [2:0] ST_POLL = 3'h4;

reg [31:0] ctrl;
reg [15:0] idle_time_before_sleep;
reg [15:0] cyclic_sleep_period;
reg [2:0] state;
reg [2:0] next_state;
reg [31:0] tick_cnt;
reg tick;
reg [15:0] idle_cnt;
reg [15:0] period_cnt;
reg [31:0] wake_cnt;
reg [31:0] next_wake_cnt;
reg req_s1;
reg req_s2;
reg req_d;
reg pin_woke;
reg next_pin_woke;
reg next_poll;
reg wake_polls;
reg next_wake_polls;

wire [2:0] sleep_config = ctrl[`SMC_CTRL_CFG_MSB:`SMC_CTRL_CFG_LSB];
wire poll_on_pin = ctrl[`SMC_CTRL_POLL_BIT];
wire cfg_pin = (sleep_config == `SMC_CFG_HIBERNATE) || (sleep_config == `SMC_CFG_DOZE);
wire cfg_cyc = (sleep_config == `SMC_CFG_CYCLIC) || (sleep_config == `SMC_CFG_CYCLIC_PIN);
wire activity = serial_activity | radio_activity | link_busy;
wire pin_fall = req_d & ~req_s2;
wire idle_expired = tick && (idle_cnt >= idle_time_before_sleep);
wire period_expired = tick && (period_cnt >= cyclic_sleep_period);

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser; req_s2 and its delayed copy req_d feed logic
always @(posedge aclk) begin
    if (!aresetn) begin
        req_s1 <= 1'b0;
        req_s2 <= 1'b0;
        req_d <= 1'b0;
    end else begin
        req_s1 <= sleep_request_pin;
        req_s2 <= req_s1;
        req_d <= req_s2;
    end
end

// shared tick keeps the long timers 16 bits wide
always @(posedge aclk) begin
    if (!aresetn) begin
        tick_cnt <= 32'h00000000;
        tick <= 1'b0;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
        tick_cnt <= 32'h00000000;
        tick <= 1'b1;
    end else begin
        tick_cnt <= tick_cnt + 32'h00000001;
        tick <= 1'b0;
    end
end

// idle timer runs only while awake in a cyclic setting
always @(posedge aclk) begin
    if (!aresetn) begin
        idle_cnt <= 16'h0000;
    end else if (state != ST_IDLE || !cfg_cyc || activity) begin
        idle_cnt <= 16'h0000;
    end else if (tick && idle_cnt != 16'hFFFF) begin
        idle_cnt <= idle_cnt + 16'h0001;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        period_cnt <= 16'h0000;
    end else if (state != ST_SLEEP) begin
        period_cnt <= 16'h0000;
    end else if (tick && period_cnt != 16'hFFFF) begin
        period_cnt <= period_cnt + 16'h0001;
    end
end

////////////////////////////////////////////////////////////////////////////////
always @* begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    next_pin_woke = pin_woke;
    next_poll = 1'b0;
    next_wake_polls = wake_polls;
    case (state)
        ST_IDLE: begin
            if (cfg_pin && req_s2) begin
                next_state = ST_DRAIN;
            end else if (cfg_cyc && idle_expired) begin
                next_state = ST_DRAIN;
            end
        end
        ST_DRAIN: begin
            if (sleep_config == `SMC_CFG_OFF || (cfg_pin && !req_s2)) begin
                next_state = ST_IDLE;
            end else if (!link_busy) begin
                next_state = ST_SLEEP;
            end
        end
        ST_SLEEP: begin
            next_pin_woke = 1'b0;
            if (cfg_pin) begin
                if (!req_s2) begin
                    next_state = ST_WAKE;
                    next_wake_polls = poll_on_pin;
                    if (sleep_config == `SMC_CFG_HIBERNATE) begin
                        next_wake_cnt = HIB_WAKE_CYCLES;
                    end else begin
                        next_wake_cnt = DOZE_WAKE_CYCLES;
                    end
                end
            end else if (cfg_cyc) begin
                if (sleep_config == `SMC_CFG_CYCLIC_PIN && pin_fall) begin
                    next_state = ST_WAKE;
                    next_pin_woke = 1'b1;
                    next_wake_polls = 1'b0;
                    next_wake_cnt = CYC_WAKE_CYCLES;
                end else if (period_expired) begin
                    next_state = ST_WAKE;
                    next_wake_polls = 1'b1;
                    next_wake_cnt = CYC_WAKE_CYCLES;
                end
            end else begin
                next_state = ST_IDLE;
            end
        end
        ST_WAKE: begin
            if (wake_cnt <= 32'h00000001) begin
                if (wake_polls) begin
                    next_state = ST_POLL;
                    next_poll = 1'b1;
                end else begin
                    next_state = ST_IDLE;
                end
            end else begin
                next_wake_cnt = wake_cnt - 32'h00000001;
            end
        end
        ST_POLL: begin
            if (radio_activity) begin
                next_state = ST_IDLE;
            end else if (poll_no_data) begin
                if (cfg_cyc) begin
                    next_state = ST_SLEEP;
                end else begin
                    next_state = ST_IDLE;
                end
            end
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        state <= ST_IDLE;
        wake_cnt <= 32'h00000000;
        pin_woke <= 1'b0;
        wake_polls <= 1'b0;
        poll_req <= 1'b0;
        cts_n <= 1'b0;
        asleep <= 1'b0;
        input_enable <= 1'b1;
    end else begin
        state <= next_state;
        wake_cnt <= next_wake_cnt;
        pin_woke <= next_pin_woke;
        wake_polls <= next_wake_polls;
        poll_req <= next_poll;
        // cts low once awake, in both pin and cyclic settings
        cts_n <= (next_state == ST_SLEEP) || (next_state == ST_WAKE)
            || (next_state == ST_DRAIN);
        asleep <= (next_state == ST_SLEEP);
        input_enable <= (next_state != ST_SLEEP) && (next_state != ST_WAKE);
    end
end

////////////////////////////////////////////////////////////////////////////////
// write channel: address and data taken in either order
reg aw_held;
reg w_held;
reg [3:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire [3:0] wr_addr = s_axi_awready && s_axi_awvalid ? s_axi_awaddr : aw_addr;
wire [31:0] wr_data = s_axi_wready && s_axi_wvalid ? s_axi_wdata : w_data;
wire [3:0] wr_strb = s_axi_wready && s_axi_wvalid ? s_axi_wstrb : w_strb;
wire aw_have = aw_held || (s_axi_awready && s_axi_awvalid);
wire w_have = w_held || (s_axi_wready && s_axi_wvalid);
wire do_write = aw_have && w_have && !s_axi_bvalid;

function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    end
endfunction

// timer registers keep only the low half of the merged word
wire [31:0] idle_merged = merge({16'h0000, idle_time_before_sleep}, wr_data, wr_strb);
wire [31:0] period_merged = merge({16'h0000, cyclic_sleep_period}, wr_data, wr_strb);

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 4'h0;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `SMC_RESP_OKAY;
        ctrl <= `SMC_CTRL_RST;
        idle_time_before_sleep <= `SMC_IDLE_TIME_RST;
        cyclic_sleep_period <= `SMC_PERIOD_RST;
    end else begin
        if (s_axi_awready && s_axi_awvalid) begin
            aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wready && s_axi_wvalid) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `SMC_RESP_OKAY;
            if (wr_addr == `SMC_ADDR_CTRL) begin
                ctrl <= merge(ctrl, wr_data, wr_strb) & 32'h00000107;
            end else if (wr_addr == `SMC_ADDR_IDLE_TIME) begin
                idle_time_before_sleep <= idle_merged[15:0];
            end else if (wr_addr == `SMC_ADDR_PERIOD) begin
                cyclic_sleep_period <= period_merged[15:0];
            end else if (wr_addr != `SMC_ADDR_STATUS) begin
                s_axi_bresp <= `SMC_RESP_SLVERR;
            end
        end else begin
            aw_held <= aw_have;
            w_held <= w_have;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
        s_axi_awready <= !aw_have && !s_axi_awready && !s_axi_bvalid;
        s_axi_wready <= !w_have && !s_axi_wready && !s_axi_bvalid;
    end
end

// read channel: one cycle to take, data on the following edge
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `SMC_RESP_OKAY;
    end else begin
        s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SMC_RESP_OKAY;
            if (s_axi_araddr == `SMC_ADDR_CTRL) begin
                s_axi_rdata <= ctrl;
            end else if (s_axi_araddr == `SMC_ADDR_IDLE_TIME) begin
                s_axi_rdata <= {16'h0000, idle_time_before_sleep};
            end else if (s_axi_araddr == `SMC_ADDR_PERIOD) begin
                s_axi_rdata <= {16'h0000, cyclic_sleep_period};
            end else if (s_axi_araddr == `SMC_ADDR_STATUS) begin
                s_axi_rdata <= {24'h000000, pin_woke, req_s2, input_enable, asleep, cts_n, state};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `SMC_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

// [hdl/smc_regs.vh]
`ifndef SMC_REGS_VH
`define SMC_REGS_VH

// register byte offsets
`define SMC_ADDR_CTRL 4'h0
`define SMC_ADDR_IDLE_TIME 4'h4
`define SMC_ADDR_PERIOD 4'h8
`define SMC_ADDR_STATUS 4'hC

// control register fields
`define SMC_CTRL_CFG_LSB 0
`define SMC_CTRL_CFG_MSB 2
`define SMC_CTRL_POLL_BIT 8

// reset values
`define SMC_CTRL_RST 32'h00000000
`define SMC_IDLE_TIME_RST 16'h1388
`define SMC_PERIOD_RST 16'h0064

// sleep configuration codes
`define SMC_CFG_OFF 3'h0
`define SMC_CFG_HIBERNATE 3'h1
`define SMC_CFG_DOZE 3'h2
`define SMC_CFG_CYCLIC 3'h4
`define SMC_CFG_CYCLIC_PIN 3'h5

// timing
`define SMC_CLK_MHZ 100
`define SMC_HIB_WAKE_US 13200
`define SMC_DOZE_WAKE_US 2000
`define SMC_CYC_WAKE_US 2000
`define SMC_TICK_US 1000

// bus responses
`define SMC_RESP_OKAY 2'h0
`define SMC_RESP_SLVERR 2'h2

`endif

// [testbench/smc_sleep_ctrl_properties.sv]
`timescale 1ns/1ps
module smc_sleep_ctrl_chk (
    input wire aclk, // clock
    input wire aresetn, // sync reset, active low
    input wire s_axi_arvalid, // read address valid
    input wire s_axi_arready, // read address ready
    input wire s_axi_rvalid, // read data valid
    input wire s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire link_busy, // transfer under way
    input wire cts_n, // clear-to-send, low when ready
    input wire asleep, // low-power state
    input wire input_enable, // inputs accepted
    input wire poll_req // poll pulse
);
    ////////////////////////////////////////////////////////////
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_reset_state: assert property ($rose(aresetn) |-> !asleep && !cts_n && input_enable && !poll_req)
        else $error("outputs wrong after reset");
    chk_sleep_quiet: assert property (asleep |-> cts_n && !input_enable)
        else $error("asleep while ready or accepting input");
    chk_busy_blocks: assert property (!asleep && link_busy |=> !asleep)
        else $error("slept during link activity");
    chk_poll_pulse: assert property (poll_req |=> !poll_req)
        else $error("poll request longer than one cycle");
    chk_poll_ready: assert property (poll_req |-> !cts_n && !asleep)
        else $error("poll without clear-to-send low");
    chk_cts_ready: assert property ($fell(cts_n) |-> !asleep && input_enable)
        else $error("clear-to-send low while not ready");
    chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    chk_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
endmodule

// [testbench/smc_host_model.sv]
`timescale 1ns/1ps
module smc_host_model (
    input wire aclk, // clock
    input wire aresetn, // sync reset, active low
    input wire want_sleep, // bench asks for sleep
    output reg sleep_request_pin // request pin to device
);
    reg [1:0] hold;
    ////////////////////////////////////////////////////////////
    // release lags two clock cycles so queued bytes can land
    always @(posedge aclk) begin
        if (!aresetn) begin
            sleep_request_pin <= 1'b0;
            hold <= 2'h0;
        end else if (want_sleep) begin
            sleep_request_pin <= 1'b1;
            hold <= 2'h2;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end else begin
            sleep_request_pin <= 1'b0;
        end
    end
endmodule

// [testbench/test_sleep_mode_controller.sv]
`timescale 1ns/1ps
`include "smc_regs.vh"
module test_sleep_mode_controller;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic busy = 1'b0, ser = 1'b0, rad = 1'b0, nodata = 1'b0, want = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, cts_n, asleep, in_en, poll_req, pin;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int n_errors = 0;
    int num_checks = 0;
    int n;
    always #5 aclk = ~aclk;
    smc_sleep_ctrl #(.TICK_CYCLES(4), .HIB_WAKE_CYCLES(20), .DOZE_WAKE_CYCLES(10), .CYC_WAKE_CYCLES(10))
    smc_sleep_ctrl_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_request_pin(pin),
        .link_busy(busy), .serial_activity(ser), .radio_activity(rad), .poll_no_data(nodata),
        .cts_n(cts_n), .asleep(asleep), .input_enable(in_en), .poll_req(poll_req)
    );
    smc_host_model smc_host_model_inst (.aclk(aclk), .aresetn(aresetn), .want_sleep(want), .sleep_request_pin(pin));
    ////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function logic sel(input int w);
        sel = (w == 0) ? asleep : (w == 1) ? cts_n : poll_req;
    endfunction
    task wt(input int w, input logic v, input int mx, output int k);
        k = 0;
        while (sel(w) !== v && k < mx) begin
            @(posedge aclk);
            k++;
        end
    endtask
    task wr(input [3:0] a, input [31:0] d, input [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", bresp, er);
    endtask
    task rd(input [3:0] a, input [31:0] exp, input [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", rdata, exp);
        chk("rresp", rresp, er);
    endtask
    task nodata_pulse;
        nodata <= 1'b1;
        @(posedge aclk);
        nodata <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////
    task t_reset;
        rd(`SMC_ADDR_CTRL, 32'h00000000, `SMC_RESP_OKAY);
        rd(`SMC_ADDR_IDLE_TIME, `SMC_IDLE_TIME_RST, `SMC_RESP_OKAY);
        rd(`SMC_ADDR_PERIOD, `SMC_PERIOD_RST, `SMC_RESP_OKAY);
        rd(`SMC_ADDR_STATUS, 32'h00000020, `SMC_RESP_OKAY);
        wr(`SMC_ADDR_STATUS, 32'hFFFFFFFF, `SMC_RESP_OKAY);
        rd(`SMC_ADDR_CTRL, 32'h00000000, `SMC_RESP_OKAY);
        rd(4'h2, 32'h00000000, `SMC_RESP_SLVERR);
        wr(4'h6, 32'h00000005, `SMC_RESP_SLVERR);
        want <= 1'b1;
        repeat (20) @(posedge aclk);
        chk("asleep", asleep, 1'b0);
        chk("cts_n", cts_n, 1'b0);
        want <= 1'b0;
        // let the pin drop through the synchroniser before the next config
        repeat (6) @(posedge aclk);
        $display("reset test done");
    endtask
    task t_pin(input [31:0] cfg, input int wake, input logic exp_poll);
        wr(`SMC_ADDR_CTRL, cfg, `SMC_RESP_OKAY);
        busy <= 1'b1;
        want <= 1'b1;
        repeat (20) @(posedge aclk);
        chk("asleep_busy", asleep, 1'b0);
        busy <= 1'b0;
        wt(0, 1'b1, 10, n);
        chk("cts_n_sleep", cts_n, 1'b1);
        chk("in_en_sleep", in_en, 1'b0);
        ser <= 1'b1;
        rad <= 1'b1;
        @(posedge aclk);
        ser <= 1'b0;
        rad <= 1'b0;
        repeat (4) @(posedge aclk);
        chk("asleep_ignore", asleep, 1'b1);
        want <= 1'b0;
        wt(1, 1'b0, 80, n);
        chk("wake_time", n >= wake && n <= wake + 12, 1'b1);
        chk("poll_on_wake", poll_req, exp_poll);
        chk("awake", asleep, 1'b0);
        chk("in_en_awake", in_en, 1'b1);
        if (exp_poll) nodata_pulse();
        $display("pin test done %h", cfg);
    endtask
    task t_cyclic;
        wr(`SMC_ADDR_IDLE_TIME, 32'h00000002, `SMC_RESP_OKAY);
        wr(`SMC_ADDR_PERIOD, 32'h00000003, `SMC_RESP_OKAY);
        repeat (30) @(posedge aclk);
        chk("asleep_pin_cfg", asleep, 1'b0);
        wr(`SMC_ADDR_CTRL, `SMC_CFG_CYCLIC, `SMC_RESP_OKAY);
        wt(0, 1'b1, 60, n);
        chk("asleep_idle", asleep, 1'b1);
        wt(2, 1'b1, 80, n);
        chk("period_wake", n >= 12 && n <= 40, 1'b1);
        chk("cts_n_poll", cts_n, 1'b0);
        nodata_pulse();
        wt(0, 1'b1, 3, n);
        chk("resleep", asleep, 1'b1);
        wt(2, 1'b1, 80, n);
        chk("poll_again", poll_req, 1'b1);
        rad <= 1'b1;
        @(posedge aclk);
        rad <= 1'b0;
        repeat (10) begin
            repeat (3) @(posedge aclk);
            ser <= 1'b1;
            @(posedge aclk);
            ser <= 1'b0;
            chk("kept_awake", asleep, 1'b0);
        end
        wt(0, 1'b1, 40, n);
        chk("timer_sleep", asleep, 1'b1);
        // long period so the pin test below is not overtaken
        wt(2, 1'b1, 80, n);
        wr(`SMC_ADDR_PERIOD, 32'h00000032, `SMC_RESP_OKAY);
        nodata_pulse();
        $display("cyclic test done");
    endtask
    task t_pin5;
        wr(`SMC_ADDR_CTRL, `SMC_CFG_CYCLIC_PIN, `SMC_RESP_OKAY);
        chk("asleep_before", asleep, 1'b1);
        want <= 1'b1;
        repeat (6) @(posedge aclk);
        want <= 1'b0;
        wt(1, 1'b0, 40, n);
        chk("pin_wake", asleep, 1'b0);
        chk("no_poll", poll_req, 1'b0);
        rd(`SMC_ADDR_STATUS, 32'h000000A0, `SMC_RESP_OKAY);
        want <= 1'b1;
        wt(0, 1'b1, 60, n);
        chk("sleep_pin_high", asleep, 1'b1);
        $display("cyclic pin test done");
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_pin(32'h00000001, 20, 1'b0);
        t_pin(32'h00000002, 10, 1'b0);
        t_pin(32'h00000102, 10, 1'b1);
        t_cyclic();
        t_pin5();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
bind smc_sleep_ctrl smc_sleep_ctrl_chk smc_sleep_ctrl_chk_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .link_busy(link_busy), .cts_n(cts_n),
    .asleep(asleep), .input_enable(input_enable), .poll_req(poll_req));
